/* design/tua_device.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - After load, attach press sets attach, lamp.
// - Attach press while attached detaches.
// - Reset press drops panel clears, detaching.
// - Attached status needs attach and select_b.
// - Host detach request clears attach.
// - Auto-attach strobe high during unattached load-forward while not rewinding.
// - Strobe falling edge sets attach.
// - Remote load request latches only when selected.
// - Latch drives remote-load-active and arms attach.
// - Relay delay done requests reel relay.
// - Settle done starts load delay, releases relay.
// - Load delay done drives reels, starts fault timer.
// - No vacuum in time: fault, reset, abort.
// - Vacuum closes: raise panel clears, start hold.
// - Hold expiry clears latch, strobe sets attach.
// - Host sends commands only with its select bit set, in the same cycle as select.
// - Strap makes select need attach.
// - Straps choose select_b and select_c sources.
// - Panel disable option locks attach switch while attached and selected.
// - Ready only attached, selected, idle, interlocked.
// - Ready host commands request matching ramp.
// - Detached and ready: manual jog, end-blocked.
module tua_device
  import tua_pkg::*;
#(
  parameter int unsigned DEB_CYC    = DEBOUNCE_CYC,
  parameter int unsigned RELAY_CYC  = RELAY_DLY_CYC,
  parameter int unsigned SETTLE_CYC = SETTLE_DLY_CYC,
  parameter int unsigned LOAD_CYC   = LOAD_DLY_CYC,
  parameter int unsigned FAULT_CYC  = FAULT_DLY_CYC,
  parameter int unsigned HOLD_CYC   = HOLD_DLY_CYC
)
(
  input  wire logic SYS_CLK,
  input  wire logic SYS_RST,
  tua_link_if.dev   LINK,
  input  wire logic PANEL_ATTACH_SW,
  input  wire logic PANEL_RESET_SW,
  input  wire logic MANUAL_FWD_SW,
  input  wire logic MANUAL_REV_SW,
  input  wire logic LOAD_COMPLETE_FLAG,
  input  wire logic LOAD_FORWARD_PHASE,
  input  wire logic REWIND_ACTIVE,
  input  wire logic BEGINNING_OF_TAPE_MARKER,
  input  wire logic END_OF_TAPE_MARKER,
  input  wire logic VACUUM_SWITCH_CLOSED,
  input  wire logic STRAP_AUTO_ATTACH,
  input  wire logic STRAP_SELECT_NEEDS_ATTACH,
  input  wire logic STRAP_SELECT_B_CONTINUOUS,
  input  wire logic STRAP_SELECT_C_DUPLICATES_B,
  input  wire logic STRAP_PANEL_DISABLE,
  output logic      ATTACH_LAMP,
  output logic      SELECT_OUT,
  output logic      SELECT_C_OUT,
  output logic      REEL_RELAY_REQUEST_N,
  output logic      LOAD_READY_N,
  output logic      GENERAL_RESET_N,
  output logic      RAMP_FORWARD_REQ,
  output logic      RAMP_REVERSE_REQ
);

  if (RELAY_CYC < 1 || SETTLE_CYC < 1 || LOAD_CYC < 1 || FAULT_CYC < 1 || HOLD_CYC < 1)
    $error("tua_device delay counts must be at least one");

  logic [3:0]  sw_level;
  logic [3:0]  sw_rise;
  logic [10:0] pin_level;

  // Panel switches get the long debounce; sensors and straps need only the synchroniser.
  tua_sync_deb #(.W(4), .DEB(DEB_CYC)) u_sw_sync
  (
    .clk   (SYS_CLK),
    .rst   (SYS_RST),
    .din   ({MANUAL_REV_SW, MANUAL_FWD_SW, PANEL_RESET_SW, PANEL_ATTACH_SW}),
    .level (sw_level),
    .rise  (sw_rise)
  );

  tua_sync_deb #(.W(11), .DEB(1)) u_pin_sync
  (
    .clk   (SYS_CLK),
    .rst   (SYS_RST),
    .din   ({STRAP_PANEL_DISABLE, STRAP_SELECT_C_DUPLICATES_B, STRAP_SELECT_B_CONTINUOUS,
             STRAP_SELECT_NEEDS_ATTACH, STRAP_AUTO_ATTACH, VACUUM_SWITCH_CLOSED,
             END_OF_TAPE_MARKER, BEGINNING_OF_TAPE_MARKER, REWIND_ACTIVE,
             LOAD_FORWARD_PHASE, LOAD_COMPLETE_FLAG}),
    .level (pin_level),
    .rise  ()
  );

  wire attach_press  = sw_rise[0];
  wire reset_press   = sw_rise[1];
  wire man_fwd       = sw_level[2];
  wire man_rev       = sw_level[3];
  wire load_complete = pin_level[0];
  wire load_fwd      = pin_level[1];
  wire rewinding     = pin_level[2];
  wire bot_marker    = pin_level[3];
  wire eot_marker    = pin_level[4];
  wire vacuum        = pin_level[5];
  wire strap_auto    = pin_level[6];
  wire strap_sel_att = pin_level[7];
  wire strap_b_cont  = pin_level[8];
  wire strap_c_dup   = pin_level[9];
  wire strap_lock    = pin_level[10];

  tua_rl_e     state_q;
  tua_rl_e     state_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        attach_q;
  logic        panel_clear_d_q;
  logic        panel_clear_c_q;
  logic        remote_load_latch_q;
  logic        settle_done_latch_q;
  logic        strobe_q;
  logic        vacuum_q;
  logic        fault_q;
  logic        select_a_q;
  logic        select_b_q;
  logic        select_c_q;
  logic        status_q;
  logic        ready_q;
  logic        ready_n_q;
  logic        relay_n_q;
  logic        load_ready_n_q;
  logic        gen_reset_n_q;
  logic        ramp_fwd_q;
  logic        ramp_rev_q;

  wire tmr_done = cnt_q == 32'h0;
  wire vac_rise = vacuum & ~vacuum_q;

  // Selection qualifiers.
  wire select_a = LINK.host_unit_address_match & (~strap_sel_att | attach_q);
  wire select_b = strap_b_cont | select_a;
  wire select_c = strap_c_dup ? select_b : select_a;

  // Remote load sequence events.
  // The select seen on the link this cycle qualifies the request, so a select and a
  // request that arrive together are not lost.
  wire rl_set        = ~LINK.host_remote_load_request_n & select_a & ~remote_load_latch_q;
  wire fault_evt     = state_q == RL_FAULT_WAIT && !vacuum && tmr_done;
  wire hold_done     = state_q == RL_HOLD && tmr_done;
  wire rl_active     = remote_load_latch_q && (state_q == RL_RELAY || state_q == RL_SETTLE);
  wire relay_done    = state_q == RL_SETTLE;

  // The strobe arms the attach flip-flop; its fall performs the set.
  wire strobe = ~attach_q & ((strap_auto & load_fwd & ~rewinding) | remote_load_latch_q);
  wire strobe_fall = strobe_q & ~strobe;

  // Panel toggle, unless the panel is locked by the disable option.
  wire panel_lock = strap_lock & attach_q & select_a_q;
  wire toggle     = attach_press & ~panel_lock;
  // General reset acts as a clear for one more cycle, so the strobe fall after a fault cannot attach.
  wire clear_att  = reset_press | LINK.host_detach_request | fault_evt | ~gen_reset_n_q;
  wire set_att    = panel_clear_c_q & ((toggle & ~attach_q & load_complete) | strobe_fall);

  // Motion gating.
  wire unit_ready = vacuum & ~rewinding & ~load_fwd & ~remote_load_latch_q;
  wire cmd_ready  = attach_q & select_a_q & unit_ready;
  wire jog_enable = ~attach_q & unit_ready;
  wire fwd_req    = (cmd_ready & LINK.host_forward_command) | (jog_enable & man_fwd & ~eot_marker);
  wire rev_req    = (cmd_ready & LINK.host_reverse_command) | (jog_enable & man_rev & ~bot_marker);

  always_comb
  begin
    state_d = state_q;
    cnt_d   = tmr_done ? 32'h0 : cnt_q - 32'h1;
    case (state_q)
      RL_IDLE:
        if (rl_set)
        begin
          state_d = RL_RELAY;
          cnt_d   = 32'(RELAY_CYC - 1);
        end
      RL_RELAY:
        if (tmr_done)
        begin
          state_d = RL_SETTLE;
          cnt_d   = 32'(SETTLE_CYC - 1);
        end
      RL_SETTLE:
        if (tmr_done)
        begin
          state_d = RL_LOAD_DLY;
          cnt_d   = 32'(LOAD_CYC - 1);
        end
      RL_LOAD_DLY:
        if (tmr_done)
        begin
          state_d = RL_FAULT_WAIT;
          cnt_d   = 32'(FAULT_CYC - 1);
        end
      RL_FAULT_WAIT:
        if (vacuum)
        begin
          state_d = RL_HOLD;
          cnt_d   = 32'(HOLD_CYC - 1);
        end
        else if (tmr_done)
          state_d = RL_IDLE;
      RL_HOLD:
        if (tmr_done)
          state_d = RL_IDLE;
      default:
        state_d = RL_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      state_q <= RL_IDLE;
      cnt_q   <= 32'h0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Attach flip-flop: any clear beats a set landing in the same cycle.
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      attach_q <= 1'b0;
    else if (clear_att)
      attach_q <= 1'b0;
    else if (toggle & attach_q)
      attach_q <= 1'b0;
    else if (set_att)
      attach_q <= 1'b1;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      panel_clear_d_q <= 1'b1;
      panel_clear_c_q <= 1'b1;
      vacuum_q        <= 1'b0;
      strobe_q        <= 1'b0;
    end
    else
    begin
      panel_clear_d_q <= reset_press ? 1'b0 : (vac_rise ? 1'b1 : panel_clear_d_q);
      panel_clear_c_q <= reset_press ? 1'b0 : panel_clear_d_q;
      vacuum_q        <= vacuum;
      strobe_q        <= strobe;
    end
  end

  // Each latch's set wins over its clear; a new remote load request starts the sequence again.
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      remote_load_latch_q <= 1'b0;
      settle_done_latch_q <= 1'b0;
      fault_q             <= 1'b0;
      gen_reset_n_q       <= 1'b1;
    end
    else
    begin
      remote_load_latch_q <= rl_set | (remote_load_latch_q & ~fault_evt & ~settle_done_latch_q);
      settle_done_latch_q <= hold_done | (settle_done_latch_q & ~rl_set);
      fault_q             <= fault_evt | (fault_q & ~rl_set & ~reset_press);
      gen_reset_n_q       <= ~fault_evt;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      select_a_q     <= 1'b0;
      select_b_q     <= 1'b0;
      select_c_q     <= 1'b0;
      status_q       <= 1'b0;
      ready_q        <= 1'b0;
      ready_n_q      <= 1'b1;
      relay_n_q      <= 1'b1;
      load_ready_n_q <= 1'b1;
      ramp_fwd_q     <= 1'b0;
      ramp_rev_q     <= 1'b0;
    end
    else
    begin
      select_a_q     <= select_a;
      select_b_q     <= select_b;
      select_c_q     <= select_c;
      status_q       <= attach_q & select_b_q;
      ready_q        <= cmd_ready;
      ready_n_q      <= ~cmd_ready;
      relay_n_q      <= ~(relay_done & rl_active);
      load_ready_n_q <= ~(state_q == RL_FAULT_WAIT && !vacuum);
      // Forward wins if both directions are asked at once.
      ramp_fwd_q     <= fwd_req;
      ramp_rev_q     <= rev_req & ~fwd_req;
    end
  end

  assign ATTACH_LAMP               = attach_q;
  assign SELECT_OUT                = select_a_q;
  assign SELECT_C_OUT              = select_c_q;
  assign REEL_RELAY_REQUEST_N      = relay_n_q;
  assign LOAD_READY_N              = load_ready_n_q;
  assign GENERAL_RESET_N           = gen_reset_n_q;
  assign RAMP_FORWARD_REQ          = ramp_fwd_q;
  assign RAMP_REVERSE_REQ          = ramp_rev_q;
  assign LINK.host_attached_status = status_q;
  assign LINK.host_ready_n         = ready_n_q;
  assign LINK.command_ready_out    = ready_q;
  assign LINK.load_timeout_fault   = fault_q;

endmodule

/* include/tua_pkg.sv */
package tua_pkg;

  localparam int unsigned CLK_FREQ_MHZ = 200;

  // Delay times in microseconds; each stands in for an RC network.
  localparam int unsigned DEBOUNCE_US    = 2000;
  localparam int unsigned RELAY_DLY_US   = 100;
  localparam int unsigned SETTLE_DLY_US  = 500;
  localparam int unsigned LOAD_DLY_US    = 1000;
  localparam int unsigned FAULT_DLY_US   = 5000;
  localparam int unsigned HOLD_DLY_US    = 1000;

  localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_US * CLK_FREQ_MHZ;
  localparam int unsigned RELAY_DLY_CYC  = RELAY_DLY_US * CLK_FREQ_MHZ;
  localparam int unsigned SETTLE_DLY_CYC = SETTLE_DLY_US * CLK_FREQ_MHZ;
  localparam int unsigned LOAD_DLY_CYC   = LOAD_DLY_US * CLK_FREQ_MHZ;
  localparam int unsigned FAULT_DLY_CYC  = FAULT_DLY_US * CLK_FREQ_MHZ;
  localparam int unsigned HOLD_DLY_CYC   = HOLD_DLY_US * CLK_FREQ_MHZ;

  // Controller register map, byte addresses.
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;

  // Control register fields.
  localparam int unsigned CTRL_SELECT_BIT = 0;
  localparam int unsigned CTRL_DETACH_BIT = 1;
  localparam int unsigned CTRL_RLOAD_BIT  = 2;
  localparam int unsigned CTRL_FWD_BIT    = 3;
  localparam int unsigned CTRL_REV_BIT    = 4;
  localparam int unsigned CTRL_WIDTH      = 5;
  localparam logic [4:0]  CTRL_RESET      = 5'h00;

  // Status register fields.
  localparam int unsigned STAT_ATTACHED_BIT = 0;
  localparam int unsigned STAT_READY_BIT    = 1;
  localparam int unsigned STAT_CMD_RDY_BIT  = 2;
  localparam int unsigned STAT_FAULT_BIT    = 3;

  typedef enum logic [2:0]
  {
    RL_IDLE      = 3'b000,
    RL_RELAY     = 3'b001,
    RL_SETTLE    = 3'b010,
    RL_LOAD_DLY  = 3'b011,
    RL_FAULT_WAIT = 3'b100,
    RL_HOLD      = 3'b101
  } tua_rl_e;

endpackage

/* include/tua_link_if.sv */
`timescale 1ns/1ps
interface tua_link_if;
  logic host_unit_address_match;
  logic host_detach_request;
  logic host_remote_load_request_n;
  logic host_forward_command;
  logic host_reverse_command;
  logic host_attached_status;
  logic host_ready_n;
  logic command_ready_out;
  logic load_timeout_fault;

  modport dev
  (
    input  host_unit_address_match,
    input  host_detach_request,
    input  host_remote_load_request_n,
    input  host_forward_command,
    input  host_reverse_command,
    output host_attached_status,
    output host_ready_n,
    output command_ready_out,
    output load_timeout_fault
  );

  modport host
  (
    output host_unit_address_match,
    output host_detach_request,
    output host_remote_load_request_n,
    output host_forward_command,
    output host_reverse_command,
    input  host_attached_status,
    input  host_ready_n,
    input  command_ready_out,
    input  load_timeout_fault
  );
endinterface

/* design/tua_sync_deb.sv */
`timescale 1ns/1ps
module tua_sync_deb
  import tua_pkg::*;
#(
  parameter int unsigned W   = 1,
  parameter int unsigned DEB = 1
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  if (W < 1 || DEB < 1)
    $error("tua_sync_deb needs W and DEB of at least one");

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] level_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= level_q;
    end
  end

  // A level is accepted only after it has held for DEB cycles, so contact bounce is lost.
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    logic [31:0] cnt_q;
    wire         differs = sync_q[i] != level_q[i];
    wire         settled = cnt_q == 32'(DEB - 1);
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        cnt_q      <= 32'h0;
        level_q[i] <= 1'b0;
      end
      else if (!differs)
        cnt_q <= 32'h0;
      else if (settled)
      begin
        cnt_q      <= 32'h0;
        level_q[i] <= sync_q[i];
      end
      else
        cnt_q <= cnt_q + 32'h1;
    end
  end

  assign level = level_q;
  assign rise  = level_q & ~prev_q;

endmodule

/* design/tua_host.sv */
`timescale 1ns/1ps
module tua_host
  import tua_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  tua_link_if.host         LINK,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST
);

  logic [CTRL_WIDTH-1:0] ctrl_q;
  logic                  wait_q;
  logic [31:0]           rdata_q;
  logic                  select_q;
  logic                  detach_q;
  logic                  rload_n_q;
  logic                  fwd_q;
  logic                  rev_q;

  // Each access is held one cycle by waitrequest and completes on the second edge.
  wire accept   = (AVS_READ | AVS_WRITE) & wait_q;
  wire take     = (AVS_READ | AVS_WRITE) & ~wait_q;
  wire hit_ctrl = AVS_ADDRESS == CTRL_OFFSET;
  wire hit_stat = AVS_ADDRESS == STATUS_OFFSET;
  wire wr_ctrl  = take & AVS_WRITE & hit_ctrl;

  wire [31:0] status_word = {28'h0, LINK.load_timeout_fault, LINK.command_ready_out,
                             ~LINK.host_ready_n, LINK.host_attached_status};
  wire [31:0] read_mux    = hit_ctrl ? {27'h0, ctrl_q} : (hit_stat ? status_word : 32'h0);

  // Forward, reverse and remote load go out only with the address select raised; detach does not need it.
  wire sel_bit = ctrl_q[CTRL_SELECT_BIT];

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0;
      ctrl_q  <= CTRL_RESET;
    end
    else
    begin
      wait_q  <= ~accept;
      rdata_q <= accept ? read_mux : rdata_q;
      // Detach and remote load are one-shot bits that clear themselves.
      ctrl_q  <= wr_ctrl ? AVS_WRITEDATA[CTRL_WIDTH-1:0]
                         : (ctrl_q & ~(5'h1 << CTRL_DETACH_BIT) & ~(5'h1 << CTRL_RLOAD_BIT));
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      select_q  <= 1'b0;
      detach_q  <= 1'b0;
      rload_n_q <= 1'b1;
      fwd_q     <= 1'b0;
      rev_q     <= 1'b0;
    end
    else
    begin
      select_q  <= sel_bit;
      detach_q  <= ctrl_q[CTRL_DETACH_BIT];
      rload_n_q <= ~(ctrl_q[CTRL_RLOAD_BIT] & sel_bit);
      fwd_q     <= ctrl_q[CTRL_FWD_BIT] & sel_bit;
      rev_q     <= ctrl_q[CTRL_REV_BIT] & sel_bit & ~ctrl_q[CTRL_FWD_BIT];
    end
  end

  assign AVS_READDATA                    = rdata_q;
  assign AVS_WAITREQUEST                 = wait_q;
  assign LINK.host_unit_address_match    = select_q;
  assign LINK.host_detach_request        = detach_q;
  assign LINK.host_remote_load_request_n = rload_n_q;
  assign LINK.host_forward_command       = fwd_q;
  assign LINK.host_reverse_command       = rev_q;

endmodule

/* bench/tua_link_asserts.sv */
`timescale 1ns/1ps
module tua_link_asserts
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic host_unit_address_match,
  input wire logic host_detach_request,
  input wire logic host_remote_load_request_n,
  input wire logic host_forward_command,
  input wire logic host_reverse_command,
  input wire logic host_attached_status,
  input wire logic host_ready_n,
  input wire logic command_ready_out,
  input wire logic load_timeout_fault
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);

  ready_pair_a: assert property (host_ready_n == !command_ready_out)
    else $error("ready lines disagree");
  ready_selected_a: assert property ($rose(command_ready_out) |-> host_unit_address_match)
    else $error("ready rose while unit not addressed");
  detach_clears_a: assert property (host_detach_request |-> ##[1:5] !host_attached_status)
    else $error("detach request did not clear attached status");
  detach_pulse_a: assert property (host_detach_request |=> !host_detach_request)
    else $error("detach request longer than one cycle");
  rload_select_a: assert property (!host_remote_load_request_n |-> host_unit_address_match)
    else $error("remote load sent to an unselected unit");
  rload_pulse_a: assert property (!host_remote_load_request_n |=> host_remote_load_request_n)
    else $error("remote load request longer than one cycle");
  // The unit is never ready while a remote load is running, so the request drops ready.
  rload_unready_a: assert property (!host_remote_load_request_n |-> ##[1:6] host_ready_n)
    else $error("unit stayed ready during remote load");
  fault_detach_a: assert property ($rose(load_timeout_fault) |-> ##[0:4] !host_attached_status)
    else $error("load fault left the unit attached");
  cmd_exclusive_a: assert property (!(host_forward_command && host_reverse_command))
    else $error("forward and reverse commands raised together");
endmodule

/* bench/tua_tb.sv */
`timescale 1ns/1ps
module tua_tb;
  import tua_pkg::*;
  // Short delays keep the load sequence within a few hundred cycles.
  localparam int DEB = 4;
  localparam int RLY = 8;
  localparam int STL = 6;
  localparam int LDD = 7;
  localparam int FLT = 10;
  localparam int HLD = 8;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  sw  = 4'h0;
  logic [4:0]  st  = 5'h00;
  logic        lc  = 1'b1;
  logic        lfp = 1'b0;
  logic        rwd = 1'b0;
  logic        beginning_of_tape_marker = 1'b0;
  logic        end_of_tape_marker = 1'b0;
  logic        vac = 1'b1;
  logic [3:0]  adr = 4'h0;
  logic        rd  = 1'b0;
  logic        wr  = 1'b0;
  logic [31:0] wd  = 32'h0;
  logic [31:0] rdat;
  logic        wrq;
  logic        lamp, sel, selc, relay_n, load_ready_n_n, grst_n, rf, rr;
  wire  [3:0]  mon = {grst_n, load_ready_n_n, relay_n, lamp};
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [31:0] cmdv [3] = '{32'h9, 32'h11, 32'h19};
  logic [31:0] rampv [3] = '{32'h2, 32'h1, 32'h2};

  tua_link_if tua_link_if_inst ();

  tua_device #(.DEB_CYC(DEB), .RELAY_CYC(RLY), .SETTLE_CYC(STL), .LOAD_CYC(LDD),
    .FAULT_CYC(FLT), .HOLD_CYC(HLD)) tua_device_inst
  (
    .SYS_CLK                     (clk),
    .SYS_RST                     (rst),
    .LINK                        (tua_link_if_inst),
    .PANEL_ATTACH_SW             (sw[0]),
    .PANEL_RESET_SW              (sw[1]),
    .MANUAL_FWD_SW               (sw[2]),
    .MANUAL_REV_SW               (sw[3]),
    .LOAD_COMPLETE_FLAG          (lc),
    .LOAD_FORWARD_PHASE          (lfp),
    .REWIND_ACTIVE               (rwd),
    .BEGINNING_OF_TAPE_MARKER    (beginning_of_tape_marker),
    .END_OF_TAPE_MARKER          (end_of_tape_marker),
    .VACUUM_SWITCH_CLOSED        (vac),
    .STRAP_AUTO_ATTACH           (st[0]),
    .STRAP_SELECT_NEEDS_ATTACH   (st[1]),
    .STRAP_SELECT_B_CONTINUOUS   (st[2]),
    .STRAP_SELECT_C_DUPLICATES_B (st[3]),
    .STRAP_PANEL_DISABLE         (st[4]),
    .ATTACH_LAMP                 (lamp),
    .SELECT_OUT                  (sel),
    .SELECT_C_OUT                (selc),
    .REEL_RELAY_REQUEST_N        (relay_n),
    .LOAD_READY_N                (load_ready_n_n),
    .GENERAL_RESET_N             (grst_n),
    .RAMP_FORWARD_REQ            (rf),
    .RAMP_REVERSE_REQ            (rr)
  );

  tua_host tua_host_inst
  (
    .SYS_CLK         (clk),
    .SYS_RST         (rst),
    .LINK            (tua_link_if_inst),
    .AVS_ADDRESS     (adr),
    .AVS_READ        (rd),
    .AVS_WRITE       (wr),
    .AVS_WRITEDATA   (wd),
    .AVS_READDATA    (rdat),
    .AVS_WAITREQUEST (wrq)
  );

  tua_link_asserts tua_link_asserts_inst
  (
    .SYS_CLK                    (clk),
    .SYS_RST                    (rst),
    .host_unit_address_match    (tua_link_if_inst.host_unit_address_match),
    .host_detach_request        (tua_link_if_inst.host_detach_request),
    .host_remote_load_request_n (tua_link_if_inst.host_remote_load_request_n),
    .host_forward_command       (tua_link_if_inst.host_forward_command),
    .host_reverse_command       (tua_link_if_inst.host_reverse_command),
    .host_attached_status       (tua_link_if_inst.host_attached_status),
    .host_ready_n               (tua_link_if_inst.host_ready_n),
    .command_ready_out          (tua_link_if_inst.command_ready_out),
    .load_timeout_fault         (tua_link_if_inst.load_timeout_fault)
  );

  always #2.5 clk = ~clk;

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Holds the request until waitrequest is seen low at an edge, then releases.
  task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wrq !== 1'b0 && n < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
    if (n >= 50)
      n_mismatch++;
  endtask

  task automatic wr_ctrl(input logic [31:0] d);
    logic [31:0] q;
    xfer(CTRL_OFFSET, 1'b1, d, q);
    cyc(6);
  endtask

  task automatic stat(input logic [31:0] e);
    logic [31:0] q;
    xfer(STATUS_OFFSET, 1'b0, 32'h0, q);
    chk(q, e);
  endtask

  task automatic press(input int i);
    sw[i] <= 1'b1;
    cyc(DEB + 8);
    sw[i] <= 1'b0;
    cyc(DEB + 8);
  endtask

  task automatic waitm(input int i, input logic v);
    int n;
    n = 0;
    while (mon[i] !== v && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(mon[i]), 32'(v));
  endtask

  initial
  begin
    logic [31:0] q;
    cyc(10);
    rst <= 1'b0;
    cyc(4);
    stat(32'h0);
    xfer(4'h8, 1'b0, 32'h0, q);
    chk(q, 32'h0);
    xfer(4'hc, 1'b1, 32'hffffffff, q);
    stat(32'h0);
    wr_ctrl(32'h1);
    press(0);
    chk(32'(lamp), 32'h1);
    stat(32'h7);
    for (int i = 0; i < 3; i++)
    begin
      wr_ctrl(cmdv[i]);
      chk(32'({rf, rr}), rampv[i]);
    end
    wr_ctrl(32'h1);
    chk(32'({rf, rr}), 32'h0);
    st[4] <= 1'b1;
    press(0);
    chk(32'(lamp), 32'h1);
    st[4] <= 1'b0;
    wr_ctrl(32'h0);
    stat(32'h0);
    chk(32'(lamp), 32'h1);
    wr_ctrl(32'h1);
    wr_ctrl(32'h3);
    chk(32'(lamp), 32'h0);
    press(0);
    press(0);
    chk(32'(lamp), 32'h0);
    sw[2] <= 1'b1;
    cyc(DEB + 8);
    chk(32'(rf), 32'h1);
    end_of_tape_marker <= 1'b1;
    cyc(8);
    chk(32'(rf), 32'h0);
    sw[2] <= 1'b0;
    end_of_tape_marker <= 1'b0;
    sw[3] <= 1'b1;
    cyc(DEB + 8);
    chk(32'(rr), 32'h1);
    beginning_of_tape_marker <= 1'b1;
    cyc(8);
    chk(32'(rr), 32'h0);
    sw[3] <= 1'b0;
    beginning_of_tape_marker <= 1'b0;
    st[0] <= 1'b1;
    rwd <= 1'b1;
    lfp <= 1'b1;
    cyc(8);
    lfp <= 1'b0;
    cyc(8);
    chk(32'(lamp), 32'h0);
    rwd <= 1'b0;
    lfp <= 1'b1;
    cyc(8);
    lfp <= 1'b0;
    cyc(8);
    chk(32'(lamp), 32'h1);
    wr_ctrl(32'h3);
    st[1] <= 1'b1;
    wr_ctrl(32'h1);
    chk(32'(sel), 32'h0);
    st[1] <= 1'b0;
    cyc(6);
    chk(32'(sel), 32'h1);
    st[2] <= 1'b1;
    st[3] <= 1'b1;
    wr_ctrl(32'h0);
    chk(32'(selc), 32'h1);
    st[2] <= 1'b0;
    cyc(6);
    chk(32'(selc), 32'h0);
    st[3] <= 1'b0;
    wr_ctrl(32'h1);
    press(0);
    press(1);
    chk(32'(lamp), 32'h0);
    wr_ctrl(32'h4);
    cyc(RLY + STL + 10);
    chk(32'(relay_n), 32'h1);
    vac <= 1'b0;
    wr_ctrl(32'h5);
    waitm(1, 1'b0);
    waitm(1, 1'b1);
    waitm(2, 1'b0);
    waitm(3, 1'b0);
    stat(32'h8);
    wr_ctrl(32'h5);
    waitm(2, 1'b0);
    vac <= 1'b1;
    waitm(0, 1'b1);
    stat(32'h7);
    report_and_stop();
  end
endmodule
